/* include/cvsd_pkg.sv */
// =====================================================================
// Shared constants of the delta modulator core
// =====================================================================
package cvsd_pkg;

    // History register lengths of the two variants
    localparam int HIST_LEN_LOW = 3;
    localparam int HIST_LEN_HIGH = 4;
    localparam int HIST_LEN_DEF = HIST_LEN_HIGH;

    // Reset and clear values
    localparam logic [7:0] HIST_RST = 8'h55;
    localparam logic DATA_OUT_RST = 1'b0;
    localparam logic SLOPE_RST = 1'b1;
    localparam logic COIN_OE_N_RST = 1'b1;

    // Core clock and least high time of the bit clock
    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int BIT_HI_MIN_NS = 300;
    localparam int BIT_HI_MIN_CYC =
        (BIT_HI_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    localparam int HI_CNT_W = 6;

    // Sample buffer: {serial output bit, coincidence}
    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH_DEF = 8;
    localparam int SMP_BIT_POS = 1;
    localparam int SMP_COIN_POS = 0;

endpackage : cvsd_pkg

/* rtl/sample_fifo.sv */
`timescale 1ns/100ps
// =====================================================================
// Synchronous FIFO with registered flags and registered output stage
// =====================================================================
module sample_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_cfg
        $error("sample_fifo: DEPTH must be a power of two >= 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
    logic [AW:0] count_ff, nxt_count;
    logic in_ready_ff, nxt_in_ready;
    logic out_valid_ff, nxt_out_valid;
    logic [WIDTH-1:0] out_data_ff, nxt_out_data;
    logic push, take;

    // =================================================================
    // Next state
    // =================================================================
    always_comb begin
        push = in_valid & in_ready_ff;
        take = (count_ff != '0) & (~out_valid_ff | out_ready);
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        nxt_count = count_ff;
        nxt_out_valid = out_valid_ff;
        nxt_out_data = out_data_ff;
        if (push) begin
            nxt_wr_ptr = wr_ptr_ff + 1'b1;
        end
        if (take) begin
            nxt_rd_ptr = rd_ptr_ff + 1'b1;
            nxt_out_valid = 1'b1;
            nxt_out_data = mem[rd_ptr_ff];
        end else if (out_ready) begin
            nxt_out_valid = 1'b0;
        end
        case ({push, take})
            2'b10: nxt_count = count_ff + 1'b1;
            2'b01: nxt_count = count_ff - 1'b1;
            default: nxt_count = count_ff;
        endcase
        nxt_in_ready = (nxt_count < (AW+1)'(DEPTH));
    end

    // =================================================================
    // Registers
    // =================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            in_ready_ff <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
            out_data_ff <= nxt_out_data;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    assign in_ready = in_ready_ff;
    assign out_valid = out_valid_ff;
    assign out_data = out_data_ff;

endmodule : sample_fifo

/* rtl/cvsd_core.sv */
`timescale 1ns/100ps
// =====================================================================
// =====================================================================
module cvsd_core
    import cvsd_pkg::*;
#(
    parameter int HIST_LEN = HIST_LEN_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic bit_clk,
    input wire logic enc_sel,
    input wire logic cmp_above,
    input wire logic data_in,
    output logic data_out,
    output logic slope_sink,
    output logic syl_charge,
    input wire logic coin_i,
    output logic coin_o,
    output logic coin_oe_n,
    output logic clk_err,
    output logic smp_lost,
    output logic fill_ready,
    output logic rec_valid,
    output logic [FIFO_WIDTH-1:0] rec_data,
    input wire logic rec_ready
);

    // =================================================================
    // Build checks
    // =================================================================
    if (HIST_LEN != HIST_LEN_LOW && HIST_LEN != HIST_LEN_HIGH) begin : g_bad_hist
        $error("cvsd_core: HIST_LEN must be 3 or 4");
    end
    if (BIT_HI_MIN_CYC >= (1 << HI_CNT_W)) begin : g_bad_cnt
        $error("cvsd_core: high time counter too narrow");
    end

    // =================================================================
    // Reset release
    // =================================================================
    logic [1:0] rst_pipe_ff;
    logic rst_sync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_pipe_ff <= 2'b00;
        end else begin
            rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe_ff[1];

    // =================================================================
    // Bit clock phase tracking
    // =================================================================
    typedef enum logic {PH_LOW, PH_HIGH} phase_e;

    phase_e phase_ff, nxt_phase;
    logic [HI_CNT_W-1:0] hi_cnt_ff, nxt_hi_cnt;
    logic clk_err_ff, nxt_clk_err;
    logic fall_evt;

    // A falling edge counts only after a high phase of the least width
    always_comb begin
        nxt_phase = phase_ff;
        nxt_hi_cnt = hi_cnt_ff;
        nxt_clk_err = 1'b0;
        fall_evt = 1'b0;
        case (phase_ff)
            PH_LOW: begin
                if (bit_clk) begin
                    nxt_phase = PH_HIGH;
                    nxt_hi_cnt = HI_CNT_W'(1);
                end
            end
            PH_HIGH: begin
                if (bit_clk) begin
                    if (hi_cnt_ff != '1) begin
                        nxt_hi_cnt = hi_cnt_ff + 1'b1;
                    end
                end else begin
                    nxt_phase = PH_LOW;
                    if (hi_cnt_ff >= HI_CNT_W'(BIT_HI_MIN_CYC)) begin
                        fall_evt = 1'b1;
                    end else begin
                        nxt_clk_err = 1'b1;
                    end
                end
            end
            default: begin
                nxt_phase = PH_LOW;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            phase_ff <= PH_LOW;
            hi_cnt_ff <= '0;
            clk_err_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            hi_cnt_ff <= nxt_hi_cnt;
            clk_err_ff <= nxt_clk_err;
        end
    end

    // =================================================================
    // Sign bit, history and coincidence
    // =================================================================
    logic [HIST_LEN-1:0] hist_ff, nxt_hist;
    logic data_out_ff, nxt_data_out;
    logic slope_ff, nxt_slope;
    logic coin_oe_n_ff, nxt_coin_oe_n;
    logic syl_ff, nxt_syl;
    logic push_vld_ff, nxt_push_vld;
    logic [FIFO_WIDTH-1:0] push_dat_ff, nxt_push_dat;
    logic sign_sel;
    logic coin_hit;

    always_comb begin
        // Encode takes the comparator, decode or forced signalling the data pin
        sign_sel = enc_sel ? cmp_above : data_in;
        nxt_hist = hist_ff;
        nxt_data_out = data_out_ff;
        nxt_slope = slope_ff;
        nxt_coin_oe_n = coin_oe_n_ff;
        nxt_syl = syl_ff;
        nxt_push_vld = 1'b0;
        nxt_push_dat = push_dat_ff;
        coin_hit = 1'b0;
        if (clear) begin
            nxt_hist = HIST_RST[HIST_LEN-1:0];
            nxt_data_out = DATA_OUT_RST;
            nxt_slope = SLOPE_RST;
            nxt_coin_oe_n = COIN_OE_N_RST;
            nxt_syl = 1'b0;
        end else if (fall_evt) begin
            nxt_hist = {hist_ff[HIST_LEN-2:0], sign_sel};
            coin_hit = (&nxt_hist) | ~(|nxt_hist);
            // Output is the complement of the sign, so a loop back toggles
            nxt_data_out = ~sign_sel;
            // Polarity opposes the error; idle input alternates the stream
            nxt_slope = sign_sel;
            nxt_coin_oe_n = ~coin_hit;
            nxt_syl = coin_hit;
            nxt_push_vld = 1'b1;
            nxt_push_dat[SMP_BIT_POS] = ~sign_sel;
            nxt_push_dat[SMP_COIN_POS] = coin_hit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hist_ff <= HIST_RST[HIST_LEN-1:0];
            data_out_ff <= DATA_OUT_RST;
            slope_ff <= SLOPE_RST;
            coin_oe_n_ff <= COIN_OE_N_RST;
            syl_ff <= 1'b0;
            push_vld_ff <= 1'b0;
            push_dat_ff <= '0;
        end else begin
            hist_ff <= nxt_hist;
            data_out_ff <= nxt_data_out;
            slope_ff <= nxt_slope;
            coin_oe_n_ff <= nxt_coin_oe_n;
            syl_ff <= nxt_syl;
            push_vld_ff <= nxt_push_vld;
            push_dat_ff <= nxt_push_dat;
        end
    end

    // =================================================================
    // Sample buffer toward the user side
    // =================================================================
    logic fifo_in_ready;
    logic lost_ff, nxt_lost;
    logic fill_ready_ff, nxt_fill_ready;

    sample_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(core_clk),
        .rst_n(rst_sync_n),
        .in_valid(push_vld_ff),
        .in_data(push_dat_ff),
        .in_ready(fifo_in_ready),
        .out_valid(rec_valid),
        .out_data(rec_data),
        .out_ready(rec_ready)
    );

    // The bit clock cannot be held off, so a full buffer drops the sample
    always_comb begin
        nxt_lost = push_vld_ff & ~fifo_in_ready;
        nxt_fill_ready = fifo_in_ready;
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lost_ff <= 1'b0;
            fill_ready_ff <= 1'b0;
        end else begin
            lost_ff <= nxt_lost;
            fill_ready_ff <= nxt_fill_ready;
        end
    end

    // =================================================================
    // Outputs
    // =================================================================
    assign data_out = data_out_ff;
    assign slope_sink = slope_ff;
    assign syl_charge = syl_ff;
    assign coin_o = 1'b0;
    assign coin_oe_n = coin_oe_n_ff;
    assign clk_err = clk_err_ff;
    assign smp_lost = lost_ff;
    assign fill_ready = fill_ready_ff;

    // =================================================================
    // Checks
    // =================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_n);

    slope_sign_a: assert property (
        fall_evt && !clear |=> slope_ff == $past(sign_sel))
        else $error("integrator polarity does not follow sign bit");

    out_invert_a: assert property (
        fall_evt && !clear |=> data_out_ff != slope_ff)
        else $error("serial output is not the inverse of the sign");

    out_hold_a: assert property (
        !fall_evt && !clear |=> $stable(data_out_ff))
        else $error("serial output changed without a falling edge");

    coin_level_a: assert property (
        fall_evt && !clear |=> coin_oe_n_ff == !((&hist_ff) || !(|hist_ff)))
        else $error("coincidence disagrees with history");

    hist_shift_a: assert property (
        fall_evt && !clear |=> hist_ff == {$past(hist_ff[HIST_LEN-2:0]), $past(sign_sel)})
        else $error("history did not advance by one");

    enc_path_a: assert property (
        fall_evt && !clear && enc_sel |=> slope_ff == $past(cmp_above))
        else $error("encode did not take the comparator");

    dec_invert_a: assert property (
        fall_evt && !clear && !enc_sel |=> data_out_ff == !$past(data_in))
        else $error("decode output is not the complement of input");

    syl_drive_a: assert property (
        syl_charge != coin_oe_n)
        else $error("syllabic drive disagrees with coincidence");

    clear_state_a: assert property (
        clear |=> coin_oe_n_ff && !data_out_ff && !syl_ff)
        else $error("clear did not restore idle state");

    push_once_a: assert property (
        fall_evt && !clear |=> push_vld_ff ##1 !push_vld_ff)
        else $error("sample not pushed once per bit");

endmodule : cvsd_core

/* bench/remote_codec.sv */
`timescale 1ns/100ps
// =====================================================================
// Far codec: bit clock source and serial data source
// =====================================================================
module remote_codec (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [5:0] hi_cyc,
    input wire logic loop_back,
    input wire logic tx_bit,
    input wire logic rx_bit,
    output logic bit_clk,
    output logic data_in
);
    // Least low time of the bit clock, 900 ns
    localparam int LO_CYC = 36;
    logic [5:0] cnt;

    initial begin
        bit_clk = 1'b0;
        cnt = 6'h00;
    end

    // =================================================================
    // Bit clock, still while not running
    // =================================================================
    always @(posedge core_clk) begin
        if (!run) begin
            bit_clk <= 1'b0;
            cnt <= 6'h00;
        end else if (cnt + 6'h01 >= (bit_clk ? hi_cyc : 6'(LO_CYC))) begin
            bit_clk <= ~bit_clk;
            cnt <= 6'h00;
        end else begin
            cnt <= cnt + 6'h01;
        end
    end

    // Looped output forms the idle pattern, else forced signalling bits
    assign data_in = loop_back ? rx_bit : tx_bit;
endmodule : remote_codec

/* bench/cvsd_delta_modulator_logic_test.sv */
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
// =====================================================================
// Self-checking bench of the delta modulator core
// =====================================================================
module cvsd_delta_modulator_logic_test
    import cvsd_pkg::*;
;
    localparam int N = HIST_LEN_HIGH;
    localparam int CAP = FIFO_DEPTH_DEF + 1;
    logic core_clk = 1'b0;
    logic rst_n, clear, enc_sel, cmp_above, rec_ready, run, loop_back, tx_bit, stall;
    logic [5:0] hi_cyc;
    logic bit_clk, data_in, data_out, slope_sink, syl_charge, coin_i, coin_o, coin_oe_n;
    logic clk_err, smp_lost, fill_ready, rec_valid;
    logic [FIFO_WIDTH-1:0] rec_data;
    int n_fail = 0, checked = 0, n_err = 0, e_err = 0, n_lost = 0, e_lost = 0, lvl = 0;
    logic e_do, e_sl, e_coin;
    logic [1:0] w;
    bit hist[$];
    logic [1:0] exp_q[$];

    always #12.5 core_clk = ~core_clk;
    // Open-drain pin with pull-up
    assign coin_i = coin_oe_n ? 1'b1 : coin_o;

    cvsd_core #(.HIST_LEN(N), .FIFO_DEPTH(FIFO_DEPTH_DEF)) u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .clear(clear), .bit_clk(bit_clk),
        .enc_sel(enc_sel), .cmp_above(cmp_above), .data_in(data_in),
        .data_out(data_out), .slope_sink(slope_sink), .syl_charge(syl_charge),
        .coin_i(coin_i), .coin_o(coin_o), .coin_oe_n(coin_oe_n), .clk_err(clk_err),
        .smp_lost(smp_lost), .fill_ready(fill_ready), .rec_valid(rec_valid),
        .rec_data(rec_data), .rec_ready(rec_ready));

    remote_codec u_far (.core_clk(core_clk), .run(run), .hi_cyc(hi_cyc),
        .loop_back(loop_back), .tx_bit(tx_bit), .rx_bit(data_out),
        .bit_clk(bit_clk), .data_in(data_in));

    // =================================================================
    // Consumer and pulse counters
    // =================================================================
    always @(posedge core_clk) begin
        rec_ready <= stall ? 1'b0 : 1'($urandom_range(1));
        if (clk_err === 1'b1) n_err++;
        if (smp_lost === 1'b1) n_lost++;
        if (rec_valid === 1'b1 && rec_ready === 1'b1) begin
            if (exp_q.size() == 0) `CHK("rec_extra", 1'b0, 1'b1)
            else begin
                w = exp_q.pop_front();
                `CHK("rec_bit", w[1], rec_data[SMP_BIT_POS])
                `CHK("rec_coin", w[0], rec_data[SMP_COIN_POS])
            end
        end
    end

    // =================================================================
    // Model and checks
    // =================================================================
    // History restarts from the alternating reset pattern, newest bit first
    task automatic model_rst();
        e_do = DATA_OUT_RST;
        e_sl = SLOPE_RST;
        e_coin = 1'b0;
        hist.delete();
        for (int i = 0; i < N; i++) hist.push_back(HIST_RST[i]);
    endtask : model_rst

    task automatic chk_outs();
        `CHK("data_out", e_do, data_out)
        `CHK("slope_sink", e_sl, slope_sink)
        `CHK("coin_o", 1'b0, coin_o)
        `CHK("coin_oe_n", ~e_coin, coin_oe_n)
        `CHK("coin_pin", ~e_coin, coin_i)
        `CHK("syl_charge", e_coin, syl_charge)
    endtask : chk_outs

    task automatic step(input logic es, input logic cmp, input logic tx, input int hi,
        input logic clr);
        logic s;
        @(posedge core_clk);
        enc_sel <= es;
        cmp_above <= cmp;
        tx_bit <= tx;
        hi_cyc <= 6'(hi);
        if (clr) begin
            clear <= 1'b1;
            @(posedge core_clk);
            clear <= 1'b0;
            @(posedge core_clk);
            #1;
            model_rst();
            chk_outs();
        end
        @(negedge bit_clk);
        if (hi < BIT_HI_MIN_CYC) e_err++;
        else begin
            s = es ? cmp : (loop_back ? e_do : tx);
            e_do = ~s;
            e_sl = s;
            hist.push_front(s);
            if (hist.size() > N) void'(hist.pop_back());
            e_coin = ((hist.sum() with (int'(item))) inside {0, N});
            if (exp_q.size() < CAP) exp_q.push_back({e_do, e_coin});
            else e_lost++;
        end
        repeat (24) @(posedge core_clk);
        #1;
        chk_outs();
    endtask : step

    task automatic results();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    initial begin
        #(25 * 20000);
        n_fail++;
        results();
    end

    initial begin
        int unused;
        unused = $urandom(62);
        rst_n = 1'b0;
        clear = 1'b0;
        enc_sel = 1'b0;
        cmp_above = 1'b0;
        rec_ready = 1'b0;
        run = 1'b0;
        loop_back = 1'b0;
        tx_bit = 1'b0;
        stall = 1'b0;
        hi_cyc = 6'h10;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        model_rst();
        chk_outs();
        @(posedge core_clk) run <= 1'b1;
        // Random encode and decode traffic
        for (int i = 0; i < 60; i++) begin
            step(1'($urandom_range(1)), 1'($urandom_range(1)), 1'($urandom_range(1)),
                int'($urandom_range(16, 12)), 1'b0);
        end
        // Runs of equal sign raise and drop coincidence
        for (int i = 0; i < 16; i++) step(1'b1, 1'(i < 8), 1'b0, 16, 1'b0);
        // Idle encoder: feedback chases a zero input, so the stream alternates
        lvl = 0;
        for (int i = 0; i < 8; i++) begin
            step(1'b1, lvl < 0, 1'b0, 16, 1'b0);
            lvl += e_sl ? 1 : -1;
            `CHK("idle_alt", 1'((i + 1) % 2), data_out)
        end
        // Output looped into input in decode
        @(posedge core_clk) loop_back <= 1'b1;
        for (int i = 0; i < 8; i++) step(1'b0, 1'b0, 1'b0, 13, 1'b0);
        @(posedge core_clk) loop_back <= 1'b0;
        // Short high phase refused, boundary accepted
        step(1'b1, 1'b1, 1'b0, BIT_HI_MIN_CYC - 1, 1'b0);
        step(1'b1, 1'b0, 1'b0, BIT_HI_MIN_CYC, 1'b0);
        // Clear in mid-run
        step(1'b0, 1'b1, 1'b1, 16, 1'b1);
        step(1'b0, 1'b1, 1'b0, 16, 1'b0);
        // Fill the buffer with the consumer stalled
        for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge core_clk);
        @(posedge core_clk) stall <= 1'b1;
        for (int i = 0; i < CAP + 2; i++) step(1'b0, 1'b0, 1'(i % 2), 14, 1'b0);
        `CHK("fill_ready_full", 1'b0, fill_ready)
        @(posedge core_clk) run <= 1'b0;
        stall <= 1'b0;
        for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge core_clk);
        repeat (4) @(posedge core_clk);
        #1;
        `CHK("fill_ready_empty", 1'b1, fill_ready)
        `CHK("left_words", 0, exp_q.size())
        `CHK("lost_count", e_lost, n_lost)
        `CHK("clk_err_count", e_err, n_err)
        results();
    end
endmodule : cvsd_delta_modulator_logic_test
